/* verilog/cpumc_regs.svh */
// Summary of operation
// - reset and power-up start in real mode
// - 64-bit submode: address 64, operand 32 default
// - prefixes override sizes for one instruction only
// - 64-bit submode exposes wide and added registers
// - code segment attribute picks long submode
// - 64-bit submode: flat space, paging required
// - compatibility submode limited to low 4 Gbytes
// - compatibility prefixes toggle 16 and 32 bits
// - compatibility: legacy segments, long-mode system mechanisms
// - real mode: 1 Mbyte, 16-bit default, no paging
// - real mode runs everything at level 0
// - never real mode while long mode active
// - protected: 4 Gbytes, 16/32 bits, segments, tasks
// - protected: identity unless paging, then page translation
// - protected mode tracks privilege levels 0 to 3
// - virtual legacy: level 3, 1 Mbyte, real addressing
// - virtual-machine flag set enters virtual legacy mode
// - flag changes only by task switch or return
// - flags pop leaves virtual-machine flag unchanged
// - with long mode enabled, entry silently ignored
// - 64-bit submode: base zero, limits ignored
// - real address: selector shifted four, plus offset
`ifndef CPUMC_REGS_SVH
`define CPUMC_REGS_SVH
`define CPUMC_OFS_CTRL 12'h000
`define CPUMC_OFS_CSEG 12'h004
`define CPUMC_OFS_VMREQ 12'h008
`define CPUMC_OFS_PREFIX 12'h00c
`define CPUMC_OFS_STATUS 12'h010
`define CPUMC_OFS_SEGSEL 12'h014
`define CPUMC_OFS_SEGBASE 12'h018
`define CPUMC_OFS_SEGLIM 12'h01c
`define CPUMC_OFS_EA_LO 12'h020
`define CPUMC_OFS_EA_HI 12'h024
`define CPUMC_OFS_LIN_LO 12'h028
`define CPUMC_OFS_LIN_HI 12'h02c
`define CPUMC_CTRL_PE 0
`define CPUMC_CTRL_PG 1
`define CPUMC_CTRL_LME 2
`define CPUMC_CSEG_L 0
`define CPUMC_CSEG_D 1
`define CPUMC_VM_VAL 0
`define CPUMC_PFX_ASZ 0
`define CPUMC_PFX_OSZ 1
`define CPUMC_PFX_EXTW 2
`define CPUMC_SRC_TASK 2'h0
`define CPUMC_SRC_RET 2'h1
`define CPUMC_SRC_POP 2'h2
`define CPUMC_RST_CTRL 3'h0
`define CPUMC_RST_CSEG 4'h0
`define CPUMC_RST_SEGLIM 32'hffffffff
`define CPUMC_REAL_SHIFT 4
`endif

/* verilog/cpumc_pkg.sv */
`default_nettype none
package cpumc_pkg;
    typedef enum logic [2:0] {
        MODE_REAL,
        MODE_PROT,
        MODE_V86,
        MODE_LONG64,
        MODE_COMPAT
    } cpumc_mode_e;
    typedef enum logic [1:0] {
        SZ_16,
        SZ_32,
        SZ_64
    } cpumc_size_e;
endpackage : cpumc_pkg
`default_nettype wire

/* verilog/cpumc_top.sv */
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "cpumc_regs.svh"
module cpumc_top (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic insn_boundary,
    output cpumc_pkg::cpumc_mode_e mode,
    output logic long_active,
    output logic [1:0] cpl,
    output cpumc_pkg::cpumc_size_e def_addr_size,
    output cpumc_pkg::cpumc_size_e def_opnd_size,
    output cpumc_pkg::cpumc_size_e eff_addr_size,
    output cpumc_pkg::cpumc_size_e eff_opnd_size,
    output logic reg_ext_en,
    output logic flat_space,
    output logic paging_on,
    output logic legacy_seg,
    output logic long_sys_mech,
    output logic hw_task_en,
    output logic limit_fault,
    output logic [63:0] lin_addr
);

////////////////////////////////////////////////////////////////////////
// apb decode
logic [2:0] ctrl_ff;
logic [3:0] cseg_ff;
logic [2:0] pfx_ff;
logic [15:0] segsel_ff;
logic [31:0] segbase_ff;
logic [31:0] seglim_ff;
logic [63:0] ea_ff;
logic vm_ff;
logic [31:0] prdata_ff;
cpumc_pkg::cpumc_mode_e mode_ff;
cpumc_pkg::cpumc_mode_e nxt_mode;
logic [1:0] cpl_ff;
logic [1:0] nxt_cpl;

wire setup = psel & ~penable;
wire access = psel & penable;
wire sel_ctrl = (paddr == `CPUMC_OFS_CTRL);
wire sel_cseg = (paddr == `CPUMC_OFS_CSEG);
wire sel_vm = (paddr == `CPUMC_OFS_VMREQ);
wire sel_pfx = (paddr == `CPUMC_OFS_PREFIX);
wire sel_stat = (paddr == `CPUMC_OFS_STATUS);
wire sel_ssel = (paddr == `CPUMC_OFS_SEGSEL);
wire sel_sbase = (paddr == `CPUMC_OFS_SEGBASE);
wire sel_slim = (paddr == `CPUMC_OFS_SEGLIM);
wire sel_ealo = (paddr == `CPUMC_OFS_EA_LO);
wire sel_eahi = (paddr == `CPUMC_OFS_EA_HI);
wire sel_linlo = (paddr == `CPUMC_OFS_LIN_LO);
wire sel_linhi = (paddr == `CPUMC_OFS_LIN_HI);
wire hit = sel_ctrl | sel_cseg | sel_vm | sel_pfx | sel_stat
    | sel_ssel | sel_sbase | sel_slim | sel_ealo | sel_eahi
    | sel_linlo | sel_linhi;
wire wr = access & pwrite & hit;

// zero wait states; read data captured in the setup cycle
assign pready = 1'b1;
assign pslverr = access & ~hit;
assign prdata = prdata_ff;

////////////////////////////////////////////////////////////////////////
// control flags seen by the mode logic
wire pe = ctrl_ff[`CPUMC_CTRL_PE];
wire pg = ctrl_ff[`CPUMC_CTRL_PG];
wire lme = ctrl_ff[`CPUMC_CTRL_LME];
wire cs_l = cseg_ff[`CPUMC_CSEG_L];
wire cs_d = cseg_ff[`CPUMC_CSEG_D];
wire [1:0] cs_cpl = cseg_ff[3:2];
// long mode needs paged protected mode, so real is impossible here
wire lma = lme & pe & pg;
assign long_active = lma;

////////////////////////////////////////////////////////////////////////
// virtual-machine flag requests
wire vm_val = pwdata[`CPUMC_VM_VAL];
wire [1:0] vm_src = pwdata[2:1];
wire vm_wr = wr & sel_vm;
wire src_task = (vm_src == `CPUMC_SRC_TASK);
wire src_ret = (vm_src == `CPUMC_SRC_RET) & (cpl_ff == 2'h0);
// a pop is not an allowed source, so it never reaches the flag
wire src_ok = src_task | src_ret;
// attempts to set while long mode is enabled drop without fault
wire vm_block = lme & vm_val;
wire vm_upd = vm_wr & src_ok & ~vm_block;

// flag register: only the two legal sources change it
always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
        vm_ff <= 1'b0;
    end else if (vm_upd) begin
        vm_ff <= vm_val;
    end
end

////////////////////////////////////////////////////////////////////////
// software registers
always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
        ctrl_ff <= `CPUMC_RST_CTRL;
        cseg_ff <= `CPUMC_RST_CSEG;
    end else begin
        if (wr & sel_ctrl) begin
            ctrl_ff <= pwdata[2:0];
        end
        if (wr & sel_cseg) begin
            cseg_ff <= pwdata[3:0];
        end
    end
end

// segment and offset operands for address formation
always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
        segsel_ff <= 16'h0000;
        segbase_ff <= 32'h00000000;
        seglim_ff <= `CPUMC_RST_SEGLIM;
        ea_ff <= 64'h0000000000000000;
    end else begin
        if (wr & sel_ssel) begin
            segsel_ff <= pwdata[15:0];
        end
        if (wr & sel_sbase) begin
            segbase_ff <= pwdata;
        end
        if (wr & sel_slim) begin
            seglim_ff <= pwdata;
        end
        if (wr & sel_ealo) begin
            ea_ff[31:0] <= pwdata;
        end
        if (wr & sel_eahi) begin
            ea_ff[63:32] <= pwdata;
        end
    end
end

// prefixes live for one instruction; a write in the boundary
// cycle wins so the next instruction keeps its prefix
wire pfx_wr = wr & sel_pfx;
always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
        pfx_ff <= 3'h0;
    end else if (pfx_wr) begin
        pfx_ff <= pwdata[2:0];
    end else if (insn_boundary) begin
        pfx_ff <= 3'h0;
    end
end

////////////////////////////////////////////////////////////////////////
// next operating mode
always_comb begin
    nxt_mode = cpumc_pkg::MODE_REAL;
    if (lma) begin
        if (cs_l) begin
            nxt_mode = cpumc_pkg::MODE_LONG64;
        end else begin
            nxt_mode = cpumc_pkg::MODE_COMPAT;
        end
    end else if (pe) begin
        if (vm_ff & ~lme) begin
            nxt_mode = cpumc_pkg::MODE_V86;
        end else begin
            nxt_mode = cpumc_pkg::MODE_PROT;
        end
    end
end

// privilege level follows the mode it will be used in
always_comb begin
    case (nxt_mode)
        cpumc_pkg::MODE_REAL: nxt_cpl = 2'h0;
        cpumc_pkg::MODE_V86: nxt_cpl = 2'h3;
        default: nxt_cpl = cs_cpl;
    endcase
end

// mode changes only between instructions
always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
        mode_ff <= cpumc_pkg::MODE_REAL;
        cpl_ff <= 2'h0;
    end else if (insn_boundary) begin
        mode_ff <= nxt_mode;
        cpl_ff <= nxt_cpl;
    end
end

assign mode = mode_ff;
assign cpl = cpl_ff;

////////////////////////////////////////////////////////////////////////
// mode properties
wire m_real = (mode_ff == cpumc_pkg::MODE_REAL);
wire m_prot = (mode_ff == cpumc_pkg::MODE_PROT);
wire m_v86 = (mode_ff == cpumc_pkg::MODE_V86);
wire m_l64 = (mode_ff == cpumc_pkg::MODE_LONG64);
wire m_cmp = (mode_ff == cpumc_pkg::MODE_COMPAT);
wire m_16 = m_real | m_v86;
wire pfx_asz = pfx_ff[`CPUMC_PFX_ASZ];
wire pfx_osz = pfx_ff[`CPUMC_PFX_OSZ];
wire pfx_extw = pfx_ff[`CPUMC_PFX_EXTW] & m_l64;

// wide registers, added registers and wide pointer only in 64-bit
assign reg_ext_en = m_l64;
assign flat_space = m_l64;
// paging is mandatory in long mode and absent in real mode
assign paging_on = (m_prot & pg) | m_l64 | m_cmp;
assign legacy_seg = m_prot | m_cmp;
assign long_sys_mech = m_l64 | m_cmp;
assign hw_task_en = m_prot;

// default sizes per mode
always_comb begin
    def_addr_size = cpumc_pkg::SZ_16;
    def_opnd_size = cpumc_pkg::SZ_16;
    if (m_l64) begin
        def_addr_size = cpumc_pkg::SZ_64;
        def_opnd_size = cpumc_pkg::SZ_32;
    end else if ((m_prot | m_cmp) & cs_d) begin
        def_addr_size = cpumc_pkg::SZ_32;
        def_opnd_size = cpumc_pkg::SZ_32;
    end
end

// per-instruction size overrides
always_comb begin
    eff_addr_size = def_addr_size;
    eff_opnd_size = def_opnd_size;
    if (m_l64) begin
        if (pfx_asz) begin
            eff_addr_size = cpumc_pkg::SZ_32;
        end
        if (pfx_extw) begin
            eff_opnd_size = cpumc_pkg::SZ_64;
        end else if (pfx_osz) begin
            eff_opnd_size = cpumc_pkg::SZ_16;
        end
    end else begin
        // outside 64-bit the prefixes toggle 16 against 32
        if (pfx_asz) begin
            eff_addr_size = (def_addr_size == cpumc_pkg::SZ_32)
                ? cpumc_pkg::SZ_16 : cpumc_pkg::SZ_32;
        end
        if (pfx_osz) begin
            eff_opnd_size = (def_opnd_size == cpumc_pkg::SZ_32)
                ? cpumc_pkg::SZ_16 : cpumc_pkg::SZ_32;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// virtual address formation
// selector shifted four bits plus 16-bit offset; the carry into
// bit 20 is kept since wrap masking is outside this block
wire [20:0] real_lin = {5'h00, segsel_ff} * 21'h000010
    + {5'h00, ea_ff[15:0]};
wire [31:0] seg_lin = segbase_ff + ea_ff[31:0];
logic [63:0] nxt_lin;
always_comb begin
    nxt_lin = 64'h0000000000000000;
    if (m_l64) begin
        nxt_lin = ea_ff;
    end else if (m_16) begin
        nxt_lin = {43'h0, real_lin};
    end else begin
        nxt_lin = {32'h0, seg_lin};
    end
end
// limits checked only where segmentation is live
wire nxt_fault = legacy_seg & (ea_ff[31:0] > seglim_ff);

logic [63:0] lin_ff;
logic fault_ff;
always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
        lin_ff <= 64'h0000000000000000;
        fault_ff <= 1'b0;
    end else begin
        lin_ff <= nxt_lin;
        fault_ff <= nxt_fault;
    end
end
assign lin_addr = lin_ff;
assign limit_fault = fault_ff;

////////////////////////////////////////////////////////////////////////
// read mux
wire [31:0] stat_word = {15'h0000, fault_ff, paging_on, pfx_ff,
    reg_ext_en, eff_opnd_size, eff_addr_size, cpl_ff, vm_ff, lma,
    mode_ff};
logic [31:0] rd_mux;
always_comb begin
    rd_mux = 32'h00000000;
    if (sel_ctrl) rd_mux = {29'h0, ctrl_ff};
    if (sel_cseg) rd_mux = {28'h0, cseg_ff};
    if (sel_vm) rd_mux = {31'h0, vm_ff};
    if (sel_pfx) rd_mux = {29'h0, pfx_ff};
    if (sel_stat) rd_mux = stat_word;
    if (sel_ssel) rd_mux = {16'h0, segsel_ff};
    if (sel_sbase) rd_mux = segbase_ff;
    if (sel_slim) rd_mux = seglim_ff;
    if (sel_ealo) rd_mux = ea_ff[31:0];
    if (sel_eahi) rd_mux = ea_ff[63:32];
    if (sel_linlo) rd_mux = lin_ff[31:0];
    if (sel_linhi) rd_mux = lin_ff[63:32];
end

// data captured in setup so the access phase needs no wait
always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
        prdata_ff <= 32'h00000000;
    end else if (setup) begin
        prdata_ff <= rd_mux;
    end
end

////////////////////////////////////////////////////////////////////////
// checks
AST_RESET_REAL: assert property (@(posedge core_clk) disable iff (!rst_b)
    (insn_boundary && !pe) |=> (mode_ff == cpumc_pkg::MODE_REAL))
    else $error("mode not real with protection off");
AST_L64_SIZES: assert property (@(posedge core_clk) disable iff (!rst_b)
    (insn_boundary && lma && cs_l) |=> (def_addr_size == cpumc_pkg::SZ_64
    && def_opnd_size == cpumc_pkg::SZ_32))
    else $error("64-bit default sizes wrong");
AST_PFX_ONE: assert property (@(posedge core_clk) disable iff (!rst_b)
    (insn_boundary && !pfx_wr) |=> (pfx_ff == 3'h0))
    else $error("prefix outlived its instruction");
AST_EXTW: assert property (@(posedge core_clk) disable iff (!rst_b)
    (m_l64 && pfx_ff[`CPUMC_PFX_EXTW]) |-> (eff_opnd_size == cpumc_pkg::SZ_64
    && reg_ext_en))
    else $error("extension prefix not widening");
AST_SUBMODE: assert property (@(posedge core_clk) disable iff (!rst_b)
    (insn_boundary && lma) |=> (cs_l ? m_l64 : m_cmp) || $past(cs_l) != cs_l)
    else $error("submode not following code segment");
AST_FLAT: assert property (@(posedge core_clk) disable iff (!rst_b)
    m_l64 && $stable(ea_ff) && $past(m_l64) |-> (lin_addr == ea_ff))
    else $error("64-bit address not flat");
AST_LOW4G: assert property (@(posedge core_clk) disable iff (!rst_b)
    $past(m_cmp) |-> (lin_addr[63:32] == 32'h0))
    else $error("compatibility address above 4 Gbytes");
AST_NO_REAL_LONG: assert property (@(posedge core_clk) disable iff (!rst_b)
    (insn_boundary && lma) |=> !m_real && !m_v86)
    else $error("legacy mode while long active");
AST_CPL_REAL: assert property (@(posedge core_clk) disable iff (!rst_b)
    m_real |-> (cpl_ff == 2'h0))
    else $error("real mode not at level 0");
AST_CPL_V86: assert property (@(posedge core_clk) disable iff (!rst_b)
    m_v86 |-> (cpl_ff == 2'h3) && paging_on == 1'b0)
    else $error("virtual legacy not at level 3");
AST_POP_KEEP: assert property (@(posedge core_clk) disable iff (!rst_b)
    (vm_wr && vm_src == `CPUMC_SRC_POP) |=> $stable(vm_ff))
    else $error("flags pop changed the flag");
AST_LME_BLOCK: assert property (@(posedge core_clk) disable iff (!rst_b)
    (vm_wr && lme && vm_val && !vm_ff) |=> !vm_ff)
    else $error("virtual legacy entered with long enabled");
AST_HOLD: assert property (@(posedge core_clk) disable iff (!rst_b)
    !insn_boundary |=> $stable(mode_ff))
    else $error("mode changed inside an instruction");

endmodule : cpumc_top
`default_nettype wire

/* test/cpumc_sw_model.sv */
`timescale 1ns/10ps
`default_nettype none
`include "cpumc_regs.svh"
// privileged software seen from the register bus: an apb master
module cpumc_sw_model (
    input wire logic core_clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // idle bus at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
    end
    ////////////////////////////////////////////////////////////////////
    // one whole transfer; tmo set when pready never comes
    task xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic err, output logic tmo);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge core_clk);
        end
        tmo = (n >= 50);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released lines show the inverse, never a stale copy
        paddr <= ~a;
        pwdata <= ~d;
    endtask : xfer
    ////////////////////////////////////////////////////////////////////
    // protection goes on first, long mode only afterwards
    task enter_long(output logic tmo);
        logic [31:0] q;
        logic e;
        logic t;
        xfer(1'b1, `CPUMC_OFS_CTRL, 32'h00000003, q, e, t);
        xfer(1'b1, `CPUMC_OFS_CTRL, 32'h00000007, q, e, tmo);
        tmo = tmo | t;
    endtask : enter_long
endmodule : cpumc_sw_model
`default_nettype wire

/* test/cpu_operating_mode_control_test.sv */
`timescale 1ns/10ps
`default_nettype none
`include "cpumc_regs.svh"
module cpu_operating_mode_control_test;
    logic core_clk;
    logic rst_b;
    logic ib;
    logic psel, penable, pwrite, pready, pslverr, last_err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    cpumc_pkg::cpumc_mode_e mode;
    cpumc_pkg::cpumc_size_e das, dos, eas, eos;
    logic long_active, reg_ext_en, flat_space, paging_on, legacy_seg;
    logic long_sys_mech, hw_task_en, limit_fault;
    logic [1:0] cpl;
    logic [63:0] lin_addr;
    int bad_count = 0;
    int compares = 0;
    cpumc_sw_model u_sw (.core_clk(core_clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    cpumc_top dut (.core_clk(core_clk), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .insn_boundary(ib), .mode(mode), .long_active(long_active), .cpl(cpl),
        .def_addr_size(das), .def_opnd_size(dos), .eff_addr_size(eas),
        .eff_opnd_size(eos), .reg_ext_en(reg_ext_en), .flat_space(flat_space),
        .paging_on(paging_on), .legacy_seg(legacy_seg),
        .long_sys_mech(long_sys_mech), .hw_task_en(hw_task_en),
        .limit_fault(limit_fault), .lin_addr(lin_addr));
    // 250 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    ////////////////////////////////////////////////////////////////////
    task end_sim;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim
    task chk(input string n, input logic [63:0] e, input logic [63:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // bus wrappers; a lost handshake ends the run
    task xf(input logic w, input logic [11:0] a, input logic [31:0] d);
        logic t;
        u_sw.xfer(w, a, d, q, last_err, t);
        // let the write's register update settle before any compare
        #1;
        if (t) begin
            bad_count++;
            end_sim();
        end
    endtask : xf
    task wr(input logic [11:0] a, input logic [31:0] d);
        xf(1'b1, a, d);
    endtask : wr
    task rd(input logic [11:0] a);
        xf(1'b0, a, 32'h00000000);
    endtask : rd
    // one instruction boundary, then let the mode register settle
    task bnd;
        @(posedge core_clk);
        ib <= 1'b1;
        @(posedge core_clk);
        ib <= 1'b0;
        @(posedge core_clk);
        #1;
    endtask : bnd
    // load selector, base and effective address, compare the result
    task ac(input logic [15:0] s, input logic [31:0] b, input logic [63:0] ea,
        input logic [63:0] e, input logic f);
        wr(`CPUMC_OFS_SEGSEL, {16'h0000, s});
        wr(`CPUMC_OFS_SEGBASE, b);
        wr(`CPUMC_OFS_EA_LO, ea[31:0]);
        wr(`CPUMC_OFS_EA_HI, ea[63:32]);
        rd(`CPUMC_OFS_LIN_LO);
        chk("lin_addr", e, lin_addr);
        chk("lin_lo", {32'h00000000, e[31:0]}, {32'h00000000, q});
        chk("limit_fault", {63'h0, f}, {63'h0, limit_fault});
    endtask : ac
    ////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        logic t;
        rst_b = 1'b0;
        ib = 1'b0;
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
        #1;
        chk("mode", cpumc_pkg::MODE_REAL, mode);
        chk("cpl", 64'h0, cpl);
        chk("def_opnd", cpumc_pkg::SZ_16, dos);
        chk("paging", 64'h0, paging_on);
        rd(`CPUMC_OFS_STATUS);
        chk("status", 64'h0, q);
        rd(`CPUMC_OFS_SEGLIM);
        chk("seglim", 64'hffffffff, q);
        rd(12'h100);
        chk("unmapped err", 64'h1, last_err);
        chk("unmapped data", 64'h0, q);
        // long enable without protection must not leave real mode
        wr(`CPUMC_OFS_CTRL, 32'h00000006);
        bnd();
        chk("mode", cpumc_pkg::MODE_REAL, mode);
        chk("long_active", 64'h0, long_active);
        wr(`CPUMC_OFS_PREFIX, 32'h00000002);
        chk("eff_opnd", cpumc_pkg::SZ_32, eos);
        bnd();
        chk("eff_opnd", cpumc_pkg::SZ_16, eos);
        ac(16'hffff, 32'h0, 64'hffff, 64'h10ffef, 1'b0);
        // protected mode at level 3, unpaged then paged
        wr(`CPUMC_OFS_CTRL, 32'h00000001);
        wr(`CPUMC_OFS_CSEG, 32'h0000000e);
        bnd();
        chk("mode", cpumc_pkg::MODE_PROT, mode);
        chk("cpl", 64'h3, cpl);
        chk("def_opnd", cpumc_pkg::SZ_32, dos);
        chk("hw_task", 64'h1, hw_task_en);
        chk("paging", 64'h0, paging_on);
        wr(`CPUMC_OFS_SEGLIM, 32'h0000001f);
        ac(16'h0, 32'h1000, 64'h20, 64'h1020, 1'b1);
        wr(`CPUMC_OFS_CTRL, 32'h00000003);
        bnd();
        chk("paging", 64'h1, paging_on);
        // virtual-machine flag: refused and accepted sources
        wr(`CPUMC_OFS_CSEG, 32'h00000002);
        bnd();
        wr(`CPUMC_OFS_VMREQ, 32'h00000005);
        rd(`CPUMC_OFS_VMREQ);
        chk("vm pop", 64'h0, q[0]);
        wr(`CPUMC_OFS_VMREQ, 32'h00000003);
        rd(`CPUMC_OFS_VMREQ);
        chk("vm ret", 64'h1, q[0]);
        bnd();
        chk("mode", cpumc_pkg::MODE_V86, mode);
        chk("cpl", 64'h3, cpl);
        ac(16'h0100, 32'h0, 64'h5, 64'h1005, 1'b0);
        wr(`CPUMC_OFS_VMREQ, 32'h00000002);
        rd(`CPUMC_OFS_VMREQ);
        chk("vm ret lvl3", 64'h1, q[0]);
        wr(`CPUMC_OFS_VMREQ, 32'h00000004);
        rd(`CPUMC_OFS_VMREQ);
        chk("vm pop", 64'h1, q[0]);
        wr(`CPUMC_OFS_VMREQ, 32'h00000000);
        rd(`CPUMC_OFS_VMREQ);
        chk("vm task", 64'h0, q[0]);
        // 64-bit submode
        u_sw.enter_long(t);
        if (t) begin
            bad_count++;
            end_sim();
        end
        wr(`CPUMC_OFS_CSEG, 32'h00000001);
        bnd();
        chk("mode", cpumc_pkg::MODE_LONG64, mode);
        chk("long_active", 64'h1, long_active);
        chk("def_addr", cpumc_pkg::SZ_64, das);
        chk("def_opnd", cpumc_pkg::SZ_32, dos);
        chk("reg_ext", 64'h1, reg_ext_en);
        chk("flat", 64'h1, flat_space);
        chk("paging", 64'h1, paging_on);
        wr(`CPUMC_OFS_PREFIX, 32'h00000004);
        chk("eff_opnd", cpumc_pkg::SZ_64, eos);
        rd(`CPUMC_OFS_STATUS);
        chk("status l64", 64'hcd0b, q);
        bnd();
        wr(`CPUMC_OFS_PREFIX, 32'h00000003);
        chk("eff_addr", cpumc_pkg::SZ_32, eas);
        chk("eff_opnd", cpumc_pkg::SZ_16, eos);
        ac(16'h0, 32'h1000, 64'h100000010, 64'h100000010, 1'b0);
        wr(`CPUMC_OFS_VMREQ, 32'h00000001);
        chk("vm err", 64'h0, last_err);
        rd(`CPUMC_OFS_VMREQ);
        chk("vm long", 64'h0, q[0]);
        bnd();
        chk("mode", cpumc_pkg::MODE_LONG64, mode);
        // compatibility submode
        wr(`CPUMC_OFS_CSEG, 32'h00000002);
        bnd();
        chk("mode", cpumc_pkg::MODE_COMPAT, mode);
        chk("legacy_seg", 64'h1, legacy_seg);
        chk("long_sys", 64'h1, long_sys_mech);
        chk("reg_ext", 64'h0, reg_ext_en);
        chk("def_addr", cpumc_pkg::SZ_32, das);
        wr(`CPUMC_OFS_PREFIX, 32'h00000001);
        chk("eff_addr", cpumc_pkg::SZ_16, eas);
        ac(16'h0, 32'h1000, 64'h100000020, 64'h1020, 1'b1);
        // reset in mid-run falls back to real mode at once
        @(posedge core_clk);
        rst_b <= 1'b0;
        #1;
        chk("mode", cpumc_pkg::MODE_REAL, mode);
        chk("long_active", 64'h0, long_active);
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        rd(`CPUMC_OFS_STATUS);
        chk("status", 64'h0, q);
        end_sim();
    end
endmodule : cpu_operating_mode_control_test
`default_nettype wire
